// ---- shared/lsau_pkg.sv ----
package lsau_pkg;

    // operation codes presented by the decode stage
    typedef enum logic [4:0] {
        LSAU_OP_NONE    = 5'h00,
        LSAU_OP_LDW     = 5'h01,
        LSAU_OP_STW     = 5'h02,
        LSAU_OP_LDH_Z   = 5'h03,
        LSAU_OP_LDH_S   = 5'h04,
        LSAU_OP_STH     = 5'h05,
        LSAU_OP_LDB_Z   = 5'h06,
        LSAU_OP_LDB_S   = 5'h07,
        LSAU_OP_STB     = 5'h08,
        LSAU_OP_LDD     = 5'h09,
        LSAU_OP_STD     = 5'h0A,
        LSAU_OP_FLG_RD  = 5'h0B,
        LSAU_OP_FLG_WR  = 5'h0C
    } lsau_op_e;

    // offset formats
    typedef enum logic [1:0] {
        LSAU_OFS_IMM  = 2'h0,
        LSAU_OFS_REG  = 2'h1,
        LSAU_OFS_SCL  = 2'h2
    } lsau_ofs_e;

    // indexing modes
    typedef enum logic [1:0] {
        LSAU_IDX_OFFSET = 2'h0,
        LSAU_IDX_PRE    = 2'h1,
        LSAU_IDX_POST   = 2'h2
    } lsau_idx_e;

    // access sizes on the data port
    localparam logic [1:0] LSAU_SZ_BYTE = 2'h0;
    localparam logic [1:0] LSAU_SZ_HALF = 2'h1;
    localparam logic [1:0] LSAU_SZ_WORD = 2'h2;

    localparam logic [3:0] LSAU_PC_IDX    = 4'hF;
    localparam int         LSAU_FLAG_LSB  = 27;
    localparam int         LSAU_FLAG_W    = 5;
    localparam logic [4:0] LSAU_FLAG_RST  = 5'h00;
    localparam logic [31:0] LSAU_DW_STEP  = 32'h0000_0004;
    localparam logic [31:0] LSAU_ALIGN_HW = 32'hFFFF_FFFE;
    localparam logic [4:0] LSAU_MAX_SHIFT = 5'h03;

    // one decoded instruction
    typedef struct packed {
        lsau_op_e    op;
        lsau_ofs_e   ofs;
        lsau_idx_e   idx;
        logic        add;
        logic        user;
        logic        excl;
        logic [3:0]  rn;
        logic [3:0]  rm;
        logic [3:0]  rt;
        logic [3:0]  rt2;
        logic [4:0]  shamt;
        logic [11:0] imm;
    } lsau_req_s;

    // one memory request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [1:0]  size;
        logic [3:0]  byte_store_instr;
        logic [31:0] wdata;
        logic        unpriv;
        logic        excl;
    } lsau_mem_s;

    // one register-file write
    typedef struct packed {
        logic        valid;
        logic [3:0]  idx;
        logic [31:0] data;
    } lsau_wb_s;

endpackage

// ---- verilog/lsau_agen.sv ----
`timescale 1ns/100ps
module lsau_agen
(
    input  wire logic [31:0]        base,
    input  wire logic [31:0]        rm_val,
    input  wire lsau_pkg::lsau_req_s req,
    output logic      [31:0]        mem_addr,
    output logic      [31:0]        wb_addr
);
    import lsau_pkg::*;

    logic [31:0] ofs;
    logic [31:0] sum;

    // offset source: unsigned immediate, register or shifted register
    always_comb
    begin
        case (req.ofs)
            LSAU_OFS_IMM: ofs = {20'h00000, req.imm};
            LSAU_OFS_REG: ofs = rm_val;
            LSAU_OFS_SCL: ofs = rm_val << req.shamt;
            default:      ofs = 32'h0000_0000;
        endcase
    end

    assign sum = req.add ? base + ofs : base - ofs;

    // post-index uses the bare base; write-back always gets the sum
    assign mem_addr = (req.idx == LSAU_IDX_POST) ? base : sum;
    assign wb_addr  = sum;
endmodule

// ---- verilog/lsau_ext.sv ----
`timescale 1ns/100ps
module lsau_ext
(
    input  wire logic [31:0]     rdata,
    input  wire lsau_pkg::lsau_op_e op,
    output logic      [31:0]     value
);
    import lsau_pkg::*;

    // narrow loads land in the low bits; upper bits zero or sign copies
    always_comb
    begin
        case (op)
            LSAU_OP_LDH_Z: value = {16'h0000, rdata[15:0]};
            LSAU_OP_LDB_Z: value = {24'h000000, rdata[7:0]};
            LSAU_OP_LDH_S: value = {{16{rdata[15]}}, rdata[15:0]};
            LSAU_OP_LDB_S: value = {{24{rdata[7]}}, rdata[7:0]};
            default:       value = rdata;
        endcase
    end
endmodule

// ---- verilog/lsau_top.sv ----
`timescale 1ns/100ps
module lsau_top
(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 req_valid,
    input  wire lsau_pkg::lsau_req_s  req,
    input  wire logic [31:0]          rn_val,
    input  wire logic [31:0]          rm_val,
    input  wire logic [31:0]          rt_val,
    input  wire logic [31:0]          rt2_val,
    input  wire logic [31:0]          pc_val,
    input  wire logic                 privileged,
    input  wire logic                 mem_ready,
    input  wire logic                 mem_rvalid,
    input  wire logic [31:0]          mem_rdata,
    output logic                      req_ready,
    output lsau_pkg::lsau_mem_s       mem_req,
    output lsau_pkg::lsau_wb_s        wb_data,
    output lsau_pkg::lsau_wb_s        wb_base,
    output logic                      branch_valid,
    output logic [31:0]               branch_target,
    output logic [4:0]                app_flags,
    output logic                      illegal
);
    import lsau_pkg::*;

    typedef enum logic [4:0] {
        LSAU_ST_IDLE  = 5'h01,
        LSAU_ST_REQ   = 5'h02,
        LSAU_ST_WAIT  = 5'h04,
        LSAU_ST_REQ2  = 5'h08,
        LSAU_ST_WAIT2 = 5'h10
    } lsau_st_e;

    lsau_st_e    state_r;
    lsau_st_e    state_nxt;
    lsau_req_s   cur_r;
    logic [31:0] base;
    logic [31:0] mem_addr;
    logic [31:0] wb_addr;
    logic [31:0] ld_value;
    logic [31:0] addr_r;
    logic [31:0] wbaddr_r;
    logic [31:0] st_hi_r;
    logic        is_load;
    logic        is_store;
    logic        is_mem;
    logic        is_dw;
    logic        is_narrow;
    logic        bad;
    logic        take;

    // loads may read the pc as base, stores may not
    assign base = (req.rn == LSAU_PC_IDX) ? pc_val : rn_val;

    assign is_load   = req.op inside {LSAU_OP_LDW, LSAU_OP_LDH_Z, LSAU_OP_LDH_S,
                                      LSAU_OP_LDB_Z, LSAU_OP_LDB_S, LSAU_OP_LDD};
    assign is_store  = req.op inside {LSAU_OP_STW, LSAU_OP_STH, LSAU_OP_STB, LSAU_OP_STD};
    assign is_mem    = is_load | is_store;
    assign is_dw     = req.op inside {LSAU_OP_LDD, LSAU_OP_STD};
    assign is_narrow = req.op inside {LSAU_OP_LDH_S, LSAU_OP_LDB_S};

    // refuse combinations the instruction set does not define
    always_comb
    begin
        bad = 1'b0;
        if (is_store && req.rn == LSAU_PC_IDX)
            bad = 1'b1;
        if (is_mem && req.ofs != LSAU_OFS_IMM && req.rm == LSAU_PC_IDX)
            bad = 1'b1;
        if (is_mem && req.ofs == LSAU_OFS_SCL && req.shamt > LSAU_MAX_SHIFT)
            bad = 1'b1;
        if (is_dw && (req.user || req.excl))
            bad = 1'b1;
        if (is_narrow && req.excl)
            bad = 1'b1;
        if (is_mem && (req.user || req.excl) && req.idx != LSAU_IDX_OFFSET)
            bad = 1'b1;
        if (req.op == LSAU_OP_NONE || req.ofs == 2'h3 || req.idx == 2'h3)
            bad = 1'b1;
    end

    assign take = req_valid && state_r == LSAU_ST_IDLE;

    lsau_agen u_agen
    (
        .base     (base),
        .rm_val   (rm_val),
        .req      (req),
        .mem_addr (mem_addr),
        .wb_addr  (wb_addr)
    );

    lsau_ext u_ext
    (
        .rdata (mem_rdata),
        .op    (cur_r.op),
        .value (ld_value)
    );

    // sequencer: one or two memory beats per instruction
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            LSAU_ST_IDLE:  if (take && !bad && is_mem) state_nxt = LSAU_ST_REQ;
            LSAU_ST_REQ:   if (mem_ready) state_nxt = LSAU_ST_WAIT;
            LSAU_ST_WAIT:
                if (mem_rvalid)
                    state_nxt = (cur_r.op inside {LSAU_OP_LDD, LSAU_OP_STD}) ?
                                LSAU_ST_REQ2 : LSAU_ST_IDLE;
            LSAU_ST_REQ2:  if (mem_ready) state_nxt = LSAU_ST_WAIT2;
            LSAU_ST_WAIT2: if (mem_rvalid) state_nxt = LSAU_ST_IDLE;
            default:       state_nxt = LSAU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= LSAU_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // capture the instruction and its addresses on acceptance
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_r    <= '0;
            addr_r   <= 32'h0000_0000;
            wbaddr_r <= 32'h0000_0000;
            st_hi_r  <= 32'h0000_0000;
        end
        else if (take)
        begin
            cur_r    <= req;
            addr_r   <= mem_addr;
            wbaddr_r <= wb_addr;
            st_hi_r  <= rt2_val;
        end
    end

    // memory request driven from flops; held until the port accepts it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            mem_req <= '0;
        else if (take && !bad && is_mem)
        begin
            mem_req.valid  <= 1'b1;
            mem_req.write  <= is_store;
            mem_req.addr   <= mem_addr;
            mem_req.excl   <= req.excl;
            // forced-unprivileged only matters while privileged
            mem_req.unpriv <= !privileged || req.user;
            case (req.op)
                LSAU_OP_STB, LSAU_OP_LDB_Z, LSAU_OP_LDB_S:
                begin
                    mem_req.size  <= LSAU_SZ_BYTE;
                    mem_req.byte_store_instr  <= 4'h1 << mem_addr[1:0];
                    mem_req.wdata <= {4{rt_val[7:0]}};
                end
                LSAU_OP_STH, LSAU_OP_LDH_Z, LSAU_OP_LDH_S:
                begin
                    mem_req.size  <= LSAU_SZ_HALF;
                    mem_req.byte_store_instr  <= mem_addr[1] ? 4'hC : 4'h3;
                    mem_req.wdata <= {2{rt_val[15:0]}};
                end
                default:
                begin
                    mem_req.size  <= LSAU_SZ_WORD;
                    mem_req.byte_store_instr  <= 4'hF;
                    mem_req.wdata <= rt_val;
                end
            endcase
            if (is_load)
                mem_req.byte_store_instr <= 4'h0;
        end
        else if (state_r == LSAU_ST_WAIT && mem_rvalid &&
                 cur_r.op inside {LSAU_OP_LDD, LSAU_OP_STD})
        begin
            // second word of a doubleword sits four bytes higher
            mem_req.valid <= 1'b1;
            mem_req.addr  <= addr_r + LSAU_DW_STEP;
            mem_req.wdata <= st_hi_r;
        end
        else if (mem_req.valid && mem_ready)
            mem_req.valid <= 1'b0;
    end

    // data write-back, pc branch and the flags register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_data       <= '0;
            branch_valid  <= 1'b0;
            branch_target <= 32'h0000_0000;
        end
        else
        begin
            wb_data.valid <= 1'b0;
            branch_valid  <= 1'b0;
            if (take && !bad && req.op == LSAU_OP_FLG_RD)
            begin
                wb_data.valid <= 1'b1;
                wb_data.idx   <= req.rt;
                wb_data.data  <= {app_flags, 27'h0000000};
            end
            else if (mem_rvalid && !mem_req.write &&
                     (state_r == LSAU_ST_WAIT || state_r == LSAU_ST_WAIT2))
            begin
                if (cur_r.op == LSAU_OP_LDW && cur_r.rt == LSAU_PC_IDX)
                begin
                    branch_valid  <= 1'b1;
                    branch_target <= ld_value;
                end
                else
                begin
                    wb_data.valid <= 1'b1;
                    wb_data.idx   <= (state_r == LSAU_ST_WAIT2) ? cur_r.rt2 : cur_r.rt;
                    wb_data.data  <= ld_value;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            app_flags <= LSAU_FLAG_RST;
        else if (take && !bad && req.op == LSAU_OP_FLG_WR)
            app_flags <= rt_val[31:LSAU_FLAG_LSB];
    end

    // base write-back at the end of the access; offset mode never writes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_base <= '0;
        else
        begin
            wb_base.valid <= 1'b0;
            if (mem_rvalid && cur_r.idx != LSAU_IDX_OFFSET &&
                ((state_r == LSAU_ST_WAIT && !(cur_r.op inside {LSAU_OP_LDD, LSAU_OP_STD}))
                 || state_r == LSAU_ST_WAIT2))
            begin
                wb_base.valid <= 1'b1;
                wb_base.idx   <= cur_r.rn;
                wb_base.data  <= wbaddr_r;
            end
        end
    end

    // handshake and decode error outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_ready <= 1'b0;
            illegal   <= 1'b0;
        end
        else
        begin
            req_ready <= (state_nxt == LSAU_ST_IDLE);
            illegal   <= take && bad;
        end
    end

    a_flag_write: assert property (@(posedge clk) disable iff (!arst_n)
        take && !bad && req.op == LSAU_OP_FLG_WR |=> app_flags == $past(rt_val[31:27]))
        else $error("flags not written");
    a_flag_read: assert property (@(posedge clk) disable iff (!arst_n)
        take && !bad && req.op == LSAU_OP_FLG_RD |=> wb_data.valid)
        else $error("flags read missing");
    a_pc_branch: assert property (@(posedge clk) disable iff (!arst_n)
        branch_valid |-> !wb_data.valid)
        else $error("pc load wrote register");
    a_byte_strobe: assert property (@(posedge clk) disable iff (!arst_n)
        mem_req.valid && mem_req.write && mem_req.size == LSAU_SZ_BYTE
        |-> $onehot(mem_req.byte_store_instr))
        else $error("byte store strobe wrong");
    a_post_addr: assert property (@(posedge clk) disable iff (!arst_n)
        take && !bad && is_mem && req.idx == LSAU_IDX_POST |=> mem_req.addr == $past(base))
        else $error("post index address wrong");
    a_offset_nowb: assert property (@(posedge clk) disable iff (!arst_n)
        wb_base.valid |-> $past(cur_r.idx) != LSAU_IDX_OFFSET)
        else $error("offset mode wrote base");
    a_unpriv_req: assert property (@(posedge clk) disable iff (!arst_n)
        take && !bad && is_mem && req.user |=> mem_req.unpriv)
        else $error("forced unprivileged lost");
    a_illegal_flag: assert property (@(posedge clk) disable iff (!arst_n)
        take && bad |=> illegal && !mem_req.valid)
        else $error("illegal not flagged");
    a_dw_second: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LSAU_ST_WAIT && mem_rvalid && cur_r.op == LSAU_OP_LDD
        |=> mem_req.valid && mem_req.addr == addr_r + 32'h4)
        else $error("second word missing");

    c_load: cover property (@(posedge clk) branch_valid);
    c_dword: cover property (@(posedge clk) state_r == LSAU_ST_WAIT2 && mem_rvalid);
    c_pre: cover property (@(posedge clk) wb_base.valid);
    c_illegal: cover property (@(posedge clk) illegal);
endmodule

// ---- tb/lsau_mem_model.sv ----
`timescale 1ns/100ps
module lsau_mem_model
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire lsau_pkg::lsau_mem_s mem_req,
    input  wire logic [3:0]          stall,
    output logic                     mem_ready,
    output logic                     mem_rvalid,
    output logic [31:0]              mem_rdata
);
    import lsau_pkg::*;
    logic [31:0] mem [0:63];
    logic [3:0]  cnt_r;
    // accept after stall cycles, finish one cycle later
    // idle read data toggles so a stale value never looks valid
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= 32'h0000_0000;
            cnt_r      <= 4'h0;
        end
        else
        begin
            mem_ready  <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            if (mem_ready)
            begin
                mem_rvalid <= 1'b1;
                // read data comes back shifted down to the low lanes
                mem_rdata  <= mem[mem_req.addr[7:2]] >> (8 * mem_req.addr[1:0]);
                for (int i = 0; i < 4; i++)
                    if (mem_req.write && mem_req.byte_store_instr[i])
                        mem[mem_req.addr[7:2]][8*i+:8] <= mem_req.wdata[8*i+:8];
            end
            else if (mem_req.valid && cnt_r == stall)
            begin
                mem_ready <= 1'b1;
                cnt_r     <= 4'h0;
            end
            else if (mem_req.valid)
                cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule

// ---- tb/lsau_top_tb.sv ----
`timescale 1ns/100ps
module lsau_top_tb;
    import lsau_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        req_valid;
    logic        privileged;
    logic        mem_ready;
    logic        mem_rvalid;
    logic        req_ready;
    logic        branch_valid;
    logic        illegal;
    logic [3:0]  stall;
    logic [4:0]  app_flags;
    logic [31:0] rn_val, rm_val, rt_val, rt2_val, pc_val, mem_rdata, branch_target;
    lsau_req_s   req;
    lsau_mem_s   mem_req;
    lsau_wb_s    wb_data;
    lsau_wb_s    wb_base;
    lsau_mem_s   mq[$];
    lsau_wb_s    wq[$];
    lsau_wb_s    bq[$];
    logic [31:0] tq[$];
    int          n_errors;
    int          n_tests;
    int          n_ill;

    lsau_top dut_u (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
        .rn_val(rn_val), .rm_val(rm_val), .rt_val(rt_val), .rt2_val(rt2_val),
        .pc_val(pc_val), .privileged(privileged), .mem_ready(mem_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .req_ready(req_ready),
        .mem_req(mem_req), .wb_data(wb_data), .wb_base(wb_base),
        .branch_valid(branch_valid), .branch_target(branch_target),
        .app_flags(app_flags), .illegal(illegal));
    lsau_mem_model mem_u (.clk(clk), .arst_n(arst_n), .mem_req(mem_req), .stall(stall),
        .mem_ready(mem_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // collect pulses and accepted memory requests
    always @(posedge clk)
    begin
        if (mem_req.valid && mem_ready)
            mq.push_back(mem_req);
        if (wb_data.valid)
            wq.push_back(wb_data);
        if (wb_base.valid)
            bq.push_back(wb_base);
        if (branch_valid)
            tq.push_back(branch_target);
        if (illegal)
            n_ill++;
    end

    // wide enough for two packed words, so paired checks keep both halves
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic lsau_req_s mk(input lsau_op_e op, input logic [3:0] rt);
        mk = '0;
        mk.op = op;
        mk.rn = 4'h2;
        mk.rm = 4'h7;
        mk.rt = rt;
        mk.add = 1'b1;
    endfunction

    // background contents, one tag per word address
    function automatic logic [31:0] pat(input logic [31:0] a);
        return 32'hA5A5_0000 | {26'h0, a[7:2]};
    endfunction

    // wait for ready, offer req for one cycle, then wait for idle so all pulses land
    task automatic go();
        int k;
        mq.delete();
        wq.delete();
        bq.delete();
        tq.delete();
        n_ill = 0;
        k = 0;
        while (req_ready !== 1'b1 && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
        while (req_ready !== 1'b1 && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        repeat (3) @(negedge clk);
        if (k >= 200)
        begin
            n_errors++;
            $display("[ERR] %0t no idle", $time);
            final_report();
        end
    endtask

    task automatic t_flags();
        req = mk(LSAU_OP_FLG_WR, 4'h5);
        rt_val = 32'hA800_0000;
        rn_val = 32'hA800_0000;
        go();
        chk(app_flags, 32'h15);
        req = mk(LSAU_OP_FLG_RD, 4'h6);
        rt_val = 32'h0;
        rn_val = 32'h0;
        go();
        chk(wq.size(), 1);
        chk(wq[0].data[31:27], 32'h15);
        chk(wq[0].idx, 32'h6);
        chk(app_flags, 32'h15);
        $display("test flags done");
    endtask

    task automatic t_modes();
        logic [31:0] ea;
        for (int m = 0; m < 3; m++)
            for (int a = 0; a < 2; a++)
            begin
                req = mk(LSAU_OP_LDW, 4'h1);
                req.idx = lsau_idx_e'(m);
                req.add = a[0];
                req.imm = 12'h010;
                rn_val = 32'h0000_0080;
                ea = a ? 32'h90 : 32'h70;
                go();
                chk(mq[0].addr, (m == 2) ? 32'h80 : ea);
                chk(mq[0].size, LSAU_SZ_WORD);
                chk(wq[0].data, pat(mq[0].addr));
                chk(bq.size(), (m == 0) ? 0 : 1);
                if (m != 0)
                    chk({bq[0].idx, bq[0].data}, {4'h2, ea});
            end
        $display("test modes done");
    endtask

    task automatic t_ofs();
        logic [31:0] o;
        for (int s = 0; s < 5; s++)
        begin
            req = mk(LSAU_OP_LDW, 4'h1);
            req.ofs = (s == 4) ? LSAU_OFS_REG : LSAU_OFS_SCL;
            req.shamt = (s == 4) ? 5'h00 : s[4:0];
            req.add = s[0];
            rn_val = 32'h80;
            rm_val = 32'h4;
            o = 32'h4 << req.shamt;
            go();
            chk(mq[0].addr, req.add ? 32'h80 + o : 32'h80 - o);
        end
        $display("test offsets done");
    endtask

    task automatic t_narrow();
        lsau_op_e    ops[4] = '{LSAU_OP_LDB_Z, LSAU_OP_LDB_S, LSAU_OP_LDH_Z, LSAU_OP_LDH_S};
        logic [31:0] ex[4] = '{32'h0000_00F0, 32'hFFFF_FF80, 32'h0000_8001, 32'hFFFF_80F0};
        mem_u.mem[16] = 32'h8001_80F0;
        for (int i = 0; i < 4; i++)
        begin
            req = mk(ops[i], 4'h3);
            req.imm = (i == 1) ? 12'h001 : (i == 2) ? 12'h002 : 12'h000;
            rn_val = 32'h40;
            go();
            chk(mq[0].size, (i < 2) ? LSAU_SZ_BYTE : LSAU_SZ_HALF);
            chk(wq[0].data, ex[i]);
        end
        $display("test narrow loads done");
    endtask

    task automatic t_store();
        lsau_op_e    ops[3] = '{LSAU_OP_STB, LSAU_OP_STH, LSAU_OP_STW};
        logic [31:0] ex[3] = '{32'h11AB_3344, 32'h5566_BEEF, 32'h0BAD_F00D};
        logic [3:0]  sb[3] = '{4'h4, 4'h3, 4'hF};
        mem_u.mem[17] = 32'h1122_3344;
        mem_u.mem[18] = 32'h5566_7788;
        rt_val = 32'h1234_56AB;
        for (int i = 0; i < 3; i++)
        begin
            req = mk(ops[i], 4'h3);
            req.imm = (i == 0) ? 12'h002 : 12'h000;
            rn_val = 32'h44 + 4 * i;
            rt_val = (i == 1) ? 32'hCAFE_BEEF : (i == 2) ? ex[2] : rt_val;
            go();
            chk({mq[0].write, mq[0].byte_store_instr}, {1'b1, sb[i]});
            chk(mem_u.mem[17 + i], ex[i]);
            chk(wq.size(), 0);
        end
        $display("test stores done");
    endtask

    task automatic t_pc();
        mem_u.mem[20] = 32'h0000_0101;
        req = mk(LSAU_OP_LDW, 4'hF);
        rn_val = 32'h50;
        go();
        chk({tq.size(), wq.size()}, {32'd1, 32'd0});
        chk(tq[0][31:1], 32'h80);
        req = mk(LSAU_OP_LDW, 4'h3);
        req.rn = 4'hF;
        req.imm = 12'h004;
        pc_val = 32'h50;
        go();
        chk(mq[0].addr, 32'h54);
        chk(wq[0].data, pat(32'h54));
        $display("test pc done");
    endtask

    task automatic t_priv();
        stall = 4'h3;
        for (int p = 0; p < 2; p++)
            for (int u = 0; u < 2; u++)
            begin
                privileged = p[0];
                req = mk(LSAU_OP_LDW, 4'h1);
                req.user = u[0];
                rn_val = 32'h40;
                go();
                chk(mq[0].unpriv, u[0] | !p[0]);
                chk(wq[0].data, 32'h8001_80F0);
            end
        stall = 4'h0;
        $display("test privilege done");
    endtask

    task automatic t_excl();
        lsau_op_e ops[3] = '{LSAU_OP_LDW, LSAU_OP_STH, LSAU_OP_LDB_Z};
        for (int i = 0; i < 3; i++)
        begin
            req = mk(ops[i], 4'h1);
            req.excl = 1'b1;
            rn_val = 32'hC0;
            go();
            chk({n_ill[15:0], mq.size(), mq[0].excl}, {16'h0, 32'h1, 1'b1});
        end
        $display("test exclusive done");
    endtask

    task automatic t_dword();
        req = mk(LSAU_OP_LDD, 4'h4);
        req.rt2 = 4'h5;
        rn_val = 32'h60;
        go();
        chk({mq[0].addr, mq[1].addr}, {32'h60, 32'h64});
        chk({wq[0].idx, wq[0].data}, {4'h4, pat(32'h60)});
        chk({wq[1].idx, wq[1].data}, {4'h5, pat(32'h64)});
        req = mk(LSAU_OP_STD, 4'h4);
        rn_val = 32'h68;
        rt_val = 32'h0102_0304;
        rt2_val = 32'h0506_0708;
        go();
        chk({mem_u.mem[26], mem_u.mem[27]}, {rt_val, rt2_val});
        $display("test dword done");
    endtask

    task automatic t_illegal();
        for (int c = 0; c < 7; c++)
        begin
            req = mk(LSAU_OP_LDW, 4'h1);
            req.op = (c == 0) ? LSAU_OP_STW : (c == 3) ? LSAU_OP_LDD : req.op;
            req.op = (c == 4) ? LSAU_OP_LDH_S : (c == 6) ? LSAU_OP_NONE : req.op;
            req.rn = (c == 0) ? 4'hF : 4'h2;
            req.ofs = (c == 1) ? LSAU_OFS_REG : (c == 2) ? LSAU_OFS_SCL : LSAU_OFS_IMM;
            req.rm = (c == 1) ? 4'hF : 4'h7;
            req.shamt = (c == 2) ? 5'h04 : 5'h00;
            req.user = (c == 3 || c == 5);
            req.excl = (c == 4);
            req.idx = (c == 5) ? LSAU_IDX_PRE : LSAU_IDX_OFFSET;
            go();
            chk(n_ill, 1);
            chk(mq.size() + wq.size() + bq.size(), 0);
        end
        $display("test illegal done");
    endtask

    initial
    begin
        n_errors = 0;
        n_tests = 0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        {rn_val, rm_val, rt_val, rt2_val, pc_val} = '0;
        privileged = 1'b1;
        stall = 4'h0;
        for (int i = 0; i < 64; i++)
            mem_u.mem[i] = pat(4 * i);
        repeat (20) @(negedge clk);
        chk({req_ready, mem_req.valid, wb_data.valid, app_flags}, 32'h0);
        arst_n = 1'b1;
        @(negedge clk);
        chk(req_ready, 1'b1);
        t_flags();
        t_modes();
        t_ofs();
        t_narrow();
        t_pc();
        t_priv();
        t_excl();
        t_dword();
        t_store();
        t_illegal();
        final_report();
    end
endmodule
